/* File: rtl/port_ab_mux_regs.vh */
// bit positions and fixed values for the port A/B alternate-function mux
// assumes inclusion by bare name from the design files
`ifndef PORT_AB_MUX_REGS_VH
`define PORT_AB_MUX_REGS_VH

// port A: back planes in bits 3..0, front plane segments in bits 7..4
`define PA_BACK_PLANE_LSB 0
`define PA_FRONT_PLANE_LSB 4
`define PA_LANE_COUNT 4

// port B: SPI pins in the lower half, compare outputs in the upper half
`define PB_SLAVE_SEL_BIT 0
`define PB_SERIAL_CLK_BIT 1
`define PB_MOSI_BIT 2
`define PB_MISO_BIT 3
`define PB_COMPARE_LSB 4

// number of the pin-change source that bit 0 of port B feeds
`define PIN_CHANGE_FIRST_SOURCE 8
`define PIN_CHANGE_LAST_SOURCE 15

// fixed override values
`define LCD_OVERRIDE_VAL 1'h0
`define PCINT_INPUT_EN_VAL 1'h1

`endif

/* File: rtl/pin_override_cell.v */
// one pad's pull-up, driver, value and input-enable override selection
// assumes override enables/values arrive from peripherals on sys_clk
`timescale 1ns/10ps

module pin_override_cell (
    input wire dirBit,
    input wire outBit,
    input wire global_pullup_disable,
    input wire deepSleep,
    input wire pullup_override_en,
    input wire pullup_override_val,
    input wire dir_override_en,
    input wire dir_override_val,
    input wire value_override_en,
    input wire value_override_val,
    input wire input_en_override_en,
    input wire input_en_override_val,
    input wire padIn,
    output wire pullupEn,
    output wire driveEnN,
    output wire padOut,
    output wire inputEn,
    output wire digIn
);

    wire driveOn;

    // without a pull-up override, pull-up only when {dir, out, disable} = 3'b010
    assign pullupEn = pullup_override_en ? pullup_override_val :
        (~dirBit & outBit & ~global_pullup_disable); // [RULE_15]
    assign driveOn = dir_override_en ? dir_override_val : dirBit; // [RULE_16]
    // active low enable: low while the pad is driven
    assign driveEnN = ~driveOn;
    // value override only matters while the driver is on
    assign padOut = (value_override_en & driveOn) ?
        value_override_val : outBit; // [RULE_17]
    assign inputEn = input_en_override_en ? input_en_override_val :
        ~deepSleep; // [RULE_18]
    // disabled input is clamped low, before any synchroniser
    assign digIn = padIn & inputEn;

endmodule

/* File: rtl/port_ab_alternate_function_mux.v */
// alternate-function override mux for two 8-bit general-purpose ports
// assumes peripherals drive their enables on sys_clk; pad inputs are async
//
// What this block does
// [RULE_01] LCD on: port A upper pins lose pull-up, driver, input; carry segments
// [RULE_02] port A bits 4..7 are segments 0..3; bits 0..3 back planes 0..3
// [RULE_03] back plane 1..3 taken when LCD on and multiplex exceeds 0..2
// [RULE_04] port B upper pins: enabled compare output replaces port value
// [RULE_05] software sets compare pin direction to output first
// [RULE_06] port B input forced on when mask bit and group-1 enable set
// [RULE_07] port B bit 0..7 are pin-change sources 8..15
// [RULE_08] SPI master forces bit 3 to input; slave leaves direction bit
// [RULE_09] SPI slave forces bit 2 to input; master leaves direction bit
// [RULE_10] SPI slave forces bit 1 to input; master leaves direction bit
// [RULE_11] SPI slave forces bit 0 input, low selects slave
// [RULE_12] forced SPI input keeps pull-up from port bit and global disable
// [RULE_13] drive slave out, master out, clock out; slave select not driven
// [RULE_14] unsynchronised SPI pin inputs feed pin-change logic and SPI
// [RULE_15] pull-up follows override, else on only for pattern 010
// [RULE_16] driver follows direction override, else port direction bit
// [RULE_17] value override replaces port bit while driver is on
// [RULE_18] input enable follows override, else normal or sleep state
// [RULE_19] override selection is combinational, same-cycle effect
`timescale 1ns/10ps
`include "port_ab_mux_regs.vh"

module port_ab_alternate_function_mux #(
    parameter WIDTH = 8,
    parameter MUX_SEL_WIDTH = 2
) (
    input wire sys_clk,
    input wire rst,
    input wire global_pullup_disable,
    input wire deepSleep,
    input wire [WIDTH-1:0] portADir,
    input wire [WIDTH-1:0] portAOut,
    input wire [WIDTH-1:0] portAPadIn,
    input wire [WIDTH-1:0] portBDir,
    input wire [WIDTH-1:0] portBOut,
    input wire [WIDTH-1:0] portBPadIn,
    input wire lcd_enable,
    input wire [MUX_SEL_WIDTH-1:0] lcd_multiplex_sel,
    input wire timer0_compare_out_a_en,
    input wire timer0_compare_out_a,
    input wire timer1_compare_out_a_en,
    input wire timer1_compare_out_a,
    input wire timer1_compare_out_b_en,
    input wire timer1_compare_out_b,
    input wire timer2_compare_out_a_en,
    input wire timer2_compare_out_a,
    input wire [WIDTH-1:0] pinChangeMask,
    input wire pin_change_group1_en,
    input wire spi_enable_bit,
    input wire spi_master_select,
    input wire spiSlaveDataOut,
    input wire spiMasterDataOut,
    input wire spiClockOut,
    output wire [WIDTH-1:0] portAPullupEn,
    output wire [WIDTH-1:0] portADriveEnN,
    output wire [WIDTH-1:0] portAPadOut,
    output wire [WIDTH-1:0] portAInputEn,
    output wire [WIDTH-1:0] portBPullupEn,
    output wire [WIDTH-1:0] portBDriveEnN,
    output wire [WIDTH-1:0] portBPadOut,
    output wire [WIDTH-1:0] portBInputEn,
    output wire [3:0] front_plane_line,
    output wire [3:0] back_plane_line,
    output wire [WIDTH-1:0] pinChangeSource,
    output wire spiMasterDataIn,
    output wire spiSlaveDataIn,
    output wire spiClockIn,
    output wire spiSlaveSelectN,
    output reg [WIDTH-1:0] portAPinSync,
    output reg [WIDTH-1:0] portBPinSync
);

    // ********************************************************
    // port A: LCD back plane and segment takeover
    // ********************************************************
    wire [WIDTH-1:0] aTake;
    wire [WIDTH-1:0] aDigIn;
    wire spiMaster;
    wire spiSlave;

    // unused back planes fall back to plain port pins
    assign aTake[`PA_BACK_PLANE_LSB] = lcd_enable; // [RULE_03]
    assign aTake[`PA_BACK_PLANE_LSB+1] = lcd_enable &
        (lcd_multiplex_sel > 2'h0); // [RULE_03]
    assign aTake[`PA_BACK_PLANE_LSB+2] = lcd_enable &
        (lcd_multiplex_sel > 2'h1); // [RULE_03]
    assign aTake[`PA_BACK_PLANE_LSB+3] = lcd_enable &
        (lcd_multiplex_sel > 2'h2); // [RULE_03]
    assign aTake[WIDTH-1:`PA_FRONT_PLANE_LSB] = {4{lcd_enable}}; // [RULE_01]

    // analog connection flags toward the LCD pads, ascending order
    assign front_plane_line =
        aTake[`PA_FRONT_PLANE_LSB +: `PA_LANE_COUNT]; // [RULE_02]
    assign back_plane_line =
        aTake[`PA_BACK_PLANE_LSB +: `PA_LANE_COUNT]; // [RULE_02]

    // ********************************************************
    // port B: SPI, compare outputs, pin change
    // ********************************************************
    wire [WIDTH-1:0] bPuOe;
    wire [WIDTH-1:0] bPvOe;
    wire [WIDTH-1:0] bPvOv;
    wire [WIDTH-1:0] bDieOe;
    wire [WIDTH-1:0] bDigIn;

    assign spiMaster = spi_enable_bit & spi_master_select;
    assign spiSlave = spi_enable_bit & ~spi_master_select;

    // same term drives pull-up and direction override per SPI pin
    assign bPuOe[`PB_MISO_BIT] = spiMaster; // [RULE_08]
    assign bPuOe[`PB_MOSI_BIT] = spiSlave; // [RULE_09]
    assign bPuOe[`PB_SERIAL_CLK_BIT] = spiSlave; // [RULE_10]
    assign bPuOe[`PB_SLAVE_SEL_BIT] = spiSlave; // [RULE_11]
    assign bPuOe[WIDTH-1:`PB_COMPARE_LSB] = 4'h0; // [RULE_04]

    assign bPvOe[`PB_MISO_BIT] = spiSlave; // [RULE_13]
    assign bPvOe[`PB_MOSI_BIT] = spiMaster; // [RULE_13]
    assign bPvOe[`PB_SERIAL_CLK_BIT] = spiMaster; // [RULE_13]
    assign bPvOe[`PB_SLAVE_SEL_BIT] = 1'h0; // [RULE_13]
    assign bPvOe[WIDTH-1:`PB_COMPARE_LSB] = {timer2_compare_out_a_en,
        timer1_compare_out_b_en, timer1_compare_out_a_en,
        timer0_compare_out_a_en}; // [RULE_04]

    assign bPvOv[`PB_MISO_BIT] = spiSlaveDataOut;
    assign bPvOv[`PB_MOSI_BIT] = spiMasterDataOut;
    assign bPvOv[`PB_SERIAL_CLK_BIT] = spiClockOut;
    assign bPvOv[`PB_SLAVE_SEL_BIT] = 1'h0;
    assign bPvOv[WIDTH-1:`PB_COMPARE_LSB] = {timer2_compare_out_a,
        timer1_compare_out_b, timer1_compare_out_a,
        timer0_compare_out_a}; // [RULE_04]

    // keeps the input alive through deep sleep for wake-up
    assign bDieOe = pinChangeMask & {WIDTH{pin_change_group1_en}}; // [RULE_06]

    // source n+8 is bit n; clamped low while input is disabled
    assign pinChangeSource = bDigIn; // [RULE_07] [RULE_14]
    // raw, unsynchronised: the SPI has its own synchroniser
    assign spiMasterDataIn = bDigIn[`PB_MISO_BIT]; // [RULE_14]
    assign spiSlaveDataIn = bDigIn[`PB_MOSI_BIT]; // [RULE_14]
    assign spiClockIn = bDigIn[`PB_SERIAL_CLK_BIT]; // [RULE_14]
    assign spiSlaveSelectN = bDigIn[`PB_SLAVE_SEL_BIT]; // [RULE_11] [RULE_14]

    // ********************************************************
    // per-pin override cells, no storage in the path
    // ********************************************************
    // pad controls stay combinational: an enable acts in its own cycle
    // port A has no value override: LCD levels use the analog path
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gen_pin
            pin_override_cell u_a (
                .dirBit(portADir[i]),
                .outBit(portAOut[i]),
                .global_pullup_disable(global_pullup_disable),
                .deepSleep(deepSleep),
                .pullup_override_en(aTake[i]), // [RULE_01] [RULE_19]
                .pullup_override_val(`LCD_OVERRIDE_VAL),
                .dir_override_en(aTake[i]), // [RULE_01]
                .dir_override_val(`LCD_OVERRIDE_VAL),
                .value_override_en(1'h0),
                .value_override_val(1'h0),
                .input_en_override_en(aTake[i]), // [RULE_01]
                .input_en_override_val(`LCD_OVERRIDE_VAL),
                .padIn(portAPadIn[i]),
                .pullupEn(portAPullupEn[i]),
                .driveEnN(portADriveEnN[i]),
                .padOut(portAPadOut[i]),
                .inputEn(portAInputEn[i]),
                .digIn(aDigIn[i])
            );
            pin_override_cell u_b (
                .dirBit(portBDir[i]),
                .outBit(portBOut[i]),
                .global_pullup_disable(global_pullup_disable),
                .deepSleep(deepSleep),
                .pullup_override_en(bPuOe[i]), // [RULE_19]
                // forced input keeps port-bit pull-up, gated by disable
                .pullup_override_val(portBOut[i] &
                    ~global_pullup_disable), // [RULE_12]
                .dir_override_en(bPuOe[i]), // [RULE_08] [RULE_09]
                .dir_override_val(1'h0), // [RULE_10] [RULE_11]
                .value_override_en(bPvOe[i]),
                .value_override_val(bPvOv[i]),
                .input_en_override_en(bDieOe[i]), // [RULE_06]
                .input_en_override_val(`PCINT_INPUT_EN_VAL),
                .padIn(portBPadIn[i]),
                .pullupEn(portBPullupEn[i]),
                .driveEnN(portBDriveEnN[i]),
                .padOut(portBPadOut[i]),
                .inputEn(portBInputEn[i]),
                .digIn(bDigIn[i])
            );
        end
    endgenerate

    // ********************************************************
    // pin read-back synchroniser, two stages
    // ********************************************************
    // first stage is read only by the second
    // reset clears only the read-back; pad controls never wait on it
    reg [WIDTH-1:0] aMeta_reg;
    reg [WIDTH-1:0] bMeta_reg;

    always @(posedge sys_clk) begin
        if (rst) begin
            aMeta_reg <= {WIDTH{1'h0}};
            bMeta_reg <= {WIDTH{1'h0}};
            portAPinSync <= {WIDTH{1'h0}};
            portBPinSync <= {WIDTH{1'h0}};
        end else begin
            aMeta_reg <= aDigIn;
            bMeta_reg <= bDigIn;
            portAPinSync <= aMeta_reg;
            portBPinSync <= bMeta_reg;
        end
    end

endmodule

/* File: bench/port_ab_mux_checker.sv */
// assertions on the port A/B alternate-function mux top ports
// assumes a bind onto the top module with default widths
`timescale 1ns/10ps

module port_ab_mux_checker (
    input wire sys_clk,
    input wire rst,
    input wire global_pullup_disable,
    input wire lcd_enable,
    input wire [1:0] lcd_multiplex_sel,
    input wire timer2_compare_out_a_en,
    input wire timer2_compare_out_a,
    input wire [7:0] portBOut,
    input wire [7:0] portBPadIn,
    input wire [7:0] pinChangeMask,
    input wire pin_change_group1_en,
    input wire spi_enable_bit,
    input wire spi_master_select,
    input wire [7:0] portAPullupEn,
    input wire [7:0] portADriveEnN,
    input wire [7:0] portAInputEn,
    input wire [7:0] portBPullupEn,
    input wire [7:0] portBDriveEnN,
    input wire [7:0] portBPadOut,
    input wire [7:0] portBInputEn,
    input wire [3:0] back_plane_line,
    input wire [7:0] pinChangeSource,
    input wire spiMasterDataIn,
    input wire spiSlaveDataIn,
    input wire spiClockIn,
    input wire spiSlaveSelectN,
    input wire [7:0] portBPinSync
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire [3:0] bpExp = {lcd_enable & (lcd_multiplex_sel > 2'h2),
        lcd_enable & (lcd_multiplex_sel > 2'h1),
        lcd_enable & (lcd_multiplex_sel > 2'h0), lcd_enable};
    // ****
    // pad control relations
    // ****
    AST_LCD_UPPER: assert property (lcd_enable |->
        portAPullupEn[7:4] == 4'h0 && portADriveEnN[7:4] == 4'hF &&
        portAInputEn[7:4] == 4'h0) else $error("segment pins not released");
    AST_BACK_PLANE: assert property (back_plane_line == bpExp &&
        (bpExp & portAInputEn[3:0]) == 4'h0) else $error("back plane wrong");
    AST_COMPARE: assert property (timer2_compare_out_a_en &&
        !portBDriveEnN[7] |-> portBPadOut[7] == timer2_compare_out_a)
        else $error("compare output not on pad");
    AST_PCINT_IE: assert property (pin_change_group1_en |->
        (pinChangeMask & ~portBInputEn) == 8'h00) else $error("input off");
    AST_PCINT_SRC: assert property (
        pinChangeSource == (portBPadIn & portBInputEn))
        else $error("pin-change source wrong");
    AST_MASTER_IN: assert property (spi_enable_bit &&
        spi_master_select |-> portBDriveEnN[3] &&
        portBPullupEn[3] == (portBOut[3] & !global_pullup_disable))
        else $error("master input pin wrong");
    AST_SLAVE_IN: assert property (
        spi_enable_bit && !spi_master_select |-> portBDriveEnN[2:0] == 3'h7)
        else $error("slave input pins driven");
    AST_SPI_DI: assert property ({spiMasterDataIn, spiSlaveDataIn,
        spiClockIn, spiSlaveSelectN} == pinChangeSource[3:0])
        else $error("spi inputs wrong");
    AST_SYNC: assert property (!$past(rst) && !$past(rst, 2) |->
        portBPinSync == $past(pinChangeSource, 2)) else $error("sync lag");
    COV_LCD_FULL: cover property (lcd_enable && lcd_multiplex_sel == 2'h3);
    COV_MASTER: cover property (spi_enable_bit && spi_master_select);
    COV_SLAVE: cover property (spi_enable_bit && !spi_master_select);
    COV_COMPARE: cover property (timer2_compare_out_a_en &&
        !portBDriveEnN[7]);
endmodule

/* File: bench/peripheral_model.sv */
// timer compare and SPI output waveforms feeding the mux
// assumes the bench owns the enables; values step on sys_clk
`timescale 1ns/10ps

module peripheral_model (
    input wire sys_clk,
    input wire rst,
    output logic [3:0] compareVal,
    output logic [2:0] spiOut
);
    logic [6:0] phase;
    always @(posedge sys_clk) begin
        // odd step so every output bit keeps changing
        phase <= rst ? 7'h00 : phase + 7'h13;
    end
    assign compareVal = phase[3:0];
    assign spiOut = phase[6:4];
endmodule

/* File: bench/port_ab_alternate_function_mux_tb_top.sv */
// self-checking bench for the port A/B alternate-function mux
// assumes peripheral_model.sv and port_ab_mux_checker.sv
`timescale 1ns/10ps

module port_ab_alternate_function_mux_tb_top;
    logic sys_clk = 0, rst = 1, pullOff, sleep, lcd, spiOn, master, grp;
    logic [1:0] mux;
    logic [3:0] cmpEn, cmpV, fp, bp, spiIn;
    logic [2:0] spiO;
    logic [7:0] aDir, aOut, aPad, bDir, bOut, bPad, mask, pcs, bSync, aSync;
    logic [7:0] aPu, aDn, aPo, aIe, bPu, bDn, bPo, bIe;
    int error_cnt = 0, checks = 0, cycles = 0;
    port_ab_alternate_function_mux i_dut (.sys_clk(sys_clk), .rst(rst),
        .global_pullup_disable(pullOff), .deepSleep(sleep),
        .portADir(aDir), .portAOut(aOut), .portAPadIn(aPad),
        .portBDir(bDir), .portBOut(bOut), .portBPadIn(bPad),
        .lcd_enable(lcd), .lcd_multiplex_sel(mux),
        .timer0_compare_out_a_en(cmpEn[0]), .timer0_compare_out_a(cmpV[0]),
        .timer1_compare_out_a_en(cmpEn[1]), .timer1_compare_out_a(cmpV[1]),
        .timer1_compare_out_b_en(cmpEn[2]), .timer1_compare_out_b(cmpV[2]),
        .timer2_compare_out_a_en(cmpEn[3]), .timer2_compare_out_a(cmpV[3]),
        .pinChangeMask(mask), .pin_change_group1_en(grp),
        .spi_enable_bit(spiOn), .spi_master_select(master),
        .spiSlaveDataOut(spiO[2]), .spiMasterDataOut(spiO[1]),
        .spiClockOut(spiO[0]), .portAPullupEn(aPu), .portADriveEnN(aDn),
        .portAPadOut(aPo), .portAInputEn(aIe), .portBPullupEn(bPu),
        .portBDriveEnN(bDn), .portBPadOut(bPo), .portBInputEn(bIe),
        .front_plane_line(fp), .back_plane_line(bp),
        .pinChangeSource(pcs), .spiMasterDataIn(spiIn[3]),
        .spiSlaveDataIn(spiIn[2]), .spiClockIn(spiIn[1]),
        .spiSlaveSelectN(spiIn[0]), .portAPinSync(aSync),
        .portBPinSync(bSync));
    peripheral_model i_per (.sys_clk(sys_clk), .rst(rst),
        .compareVal(cmpV), .spiOut(spiO));
    initial forever #2.5 sys_clk = ~sys_clk;
    // ****
    // checking helpers
    // ****
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk();
        logic [7:0] oa, fb, pv, ie;
        #1;
        oa = {{4{lcd}}, lcd & (mux > 2'h2), lcd & (mux > 2'h1),
            lcd & (mux > 2'h0), lcd};
        fb = {4'h0, spiOn & master, {3{spiOn & ~master}}};
        pv = {cmpEn, spiOn & ~master, {2{spiOn & master}}, 1'b0} & ~fb & bDir;
        ie = (mask & {8{grp}}) | {8{~sleep}};
        cmp({aPu, aDn, aIe, aPo}, {~oa & ~aDir & aOut & {8{~pullOff}},
            oa | ~aDir, ~oa & {8{~sleep}}, aOut});
        cmp({bPu, bDn, bIe, bPo}, {bOut & {8{~pullOff}} & (fb | ~bDir),
            fb | ~bDir, ie, pv & {cmpV, spiO, 1'b0} | ~pv & bOut});
        cmp({12'h000, fp, bp, pcs, spiIn}, {12'h000, {4{lcd}}, oa[3:0],
            bPad & ie, bPad[3:0] & ie[3:0]});
    endtask
    task automatic go();
        @(posedge sys_clk);
        #1;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_lcd();
        for (int i = 0; i < 8; i++) begin
            go();
            {lcd, mux} = 3'(i);
            chk();
        end
        $display("lcd done");
    endtask
    task automatic t_cmp();
        for (int i = 0; i < 5; i++) begin
            go();
            bDir = 8'hF0;
            cmpEn = 4'h1 << i;
            chk();
        end
        go();
        {bDir, cmpEn} = {8'h70, 4'hF};
        chk();
        $display("compare done");
    endtask
    task automatic t_pin_change();
        go();
        {lcd, sleep, mask, bPad} = {1'b0, 1'b1, 8'hA5, 8'h3C};
        chk();
        go();
        grp = 1'b1;
        chk();
        go();
        sleep = 1'b0;
        go();
        // two flops between pad and read-back: still the sleep view here
        cmp({16'h0, aSync, bSync}, {16'h0, 8'h00, bPad & mask});
        go();
        cmp({16'h0, aSync, bSync}, {16'h0, aPad, bPad});
        $display("pin change done");
    endtask
    task automatic t_spi();
        for (int i = 0; i < 8; i++) begin
            go();
            {bDir, bOut, grp, bPad} = {8'h0F, 8'h0B, 1'b0, 8'h5A};
            {spiOn, pullOff, master} = 3'(i);
            chk();
        end
        $display("spi done");
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 500) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        {pullOff, sleep, lcd, spiOn, master, grp, mux, cmpEn} = '0;
        {aDir, aOut, aPad, bDir, bOut, bPad, mask} = {8'h33, 8'h55, {5{8'hC6}}};
        repeat (4) @(posedge sys_clk);
        #1 rst = 0;
        t_lcd();
        t_cmp();
        t_pin_change();
        t_spi();
        end_sim();
    end
endmodule

bind port_ab_alternate_function_mux port_ab_mux_checker i_chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .global_pullup_disable(global_pullup_disable),
    .lcd_enable(lcd_enable),
    .lcd_multiplex_sel(lcd_multiplex_sel),
    .timer2_compare_out_a_en(timer2_compare_out_a_en),
    .timer2_compare_out_a(timer2_compare_out_a),
    .portBOut(portBOut),
    .portBPadIn(portBPadIn),
    .pinChangeMask(pinChangeMask),
    .pin_change_group1_en(pin_change_group1_en),
    .spi_enable_bit(spi_enable_bit),
    .spi_master_select(spi_master_select),
    .portAPullupEn(portAPullupEn),
    .portADriveEnN(portADriveEnN),
    .portAInputEn(portAInputEn),
    .portBPullupEn(portBPullupEn),
    .portBDriveEnN(portBDriveEnN),
    .portBPadOut(portBPadOut),
    .portBInputEn(portBInputEn),
    .back_plane_line(back_plane_line),
    .pinChangeSource(pinChangeSource),
    .spiMasterDataIn(spiMasterDataIn),
    .spiSlaveDataIn(spiSlaveDataIn),
    .spiClockIn(spiClockIn),
    .spiSlaveSelectN(spiSlaveSelectN),
    .portBPinSync(portBPinSync)
);
